//--- core/acsp_map.svh
// constants of the serial configuration port: instruction layout, register addresses,
// reset values and the strap capture wait
// assumes byte-wide registers and a 16-bit instruction word
`ifndef ACSP_MAP_SVH
`define ACSP_MAP_SVH

// instruction word layout
`define ACSP_INSTR_LAST   4'hf
`define ACSP_BYTE_LAST    4'h7
`define ACSP_RW_BIT       15
`define ACSP_BC_HI_BIT    14
`define ACSP_BC_LO_BIT    13
`define ACSP_ADDR_MSB     12
`define ACSP_BC_STREAM    2'h3

// register space
`define ACSP_NREGS        32
`define ACSP_ADDR_CFG     13'h0000
`define ACSP_ADDR_ID      13'h0001
`define ACSP_ADDR_GRADE   13'h0002
`define ACSP_ADDR_CLOCK   13'h0009
`define ACSP_ADDR_XFER    13'h00ff
`define ACSP_XFER_GO      8'h01

// configuration register fields, nibbles mirrored
`define ACSP_CFG_LSB_HI   6
`define ACSP_CFG_LSB_LO   1
`define ACSP_CFG_SRST_HI  5
`define ACSP_CFG_SRST_LO  2

// reset values
`define ACSP_CFG_DEFAULT   8'h18
`define ACSP_CLOCK_DEFAULT 8'h01

// clk cycles after reset release before the strap levels are taken
`define ACSP_STRAP_WAIT   3'h6

`endif

//--- core/acsp_pkg.sv
// types of the serial configuration port: frame phase and the state structs
// assumes acsp_map.svh on the include path
`include "acsp_map.svh"
`default_nettype none

package acsp_pkg;

   typedef logic [7:0] acsp_byte_t;

   typedef enum logic [0:0] {
      ACSP_INSTR = 1'b0,
      ACSP_DATA  = 1'b1
   } acsp_phase_e;

   // serial clock domain
   typedef struct packed {
      acsp_phase_e                      phase;
      logic [3:0]                       bit_cnt;
      logic [15:0]                      instr;
      logic                             rw;
      logic [1:0]                       bytes_left;
      logic                             stream;
      logic [`ACSP_ADDR_MSB:0]          addr;
      logic [7:0]                       wr_sh;
      logic                             xfer_tgl;
      logic [`ACSP_NREGS-1:0][7:0]      regs;
   } acsp_link_s;

   // system clock domain
   typedef struct packed {
      logic [`ACSP_NREGS-1:0][7:0]      active;
      logic                             xfer_seen;
      logic [2:0]                       rel_cnt;
      logic                             strap_mode;
      logic                             tp;
      logic                             rs;
   } acsp_core_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } acsp_sync_s;

endpackage : acsp_pkg

`default_nettype wire

//--- core/acsp_sync.sv
// three-stage synchroniser for one level from outside the clk domain
// assumes the input is a level; the output follows once stages two and three agree
`default_nettype none

module acsp_sync (
   input  wire logic clk,   // system clock
   input  wire logic rst_b, // async reset, active low
   input  wire logic din,   // asynchronous level
   output logic      dout   // filtered level in clk domain
);

   acsp_pkg::acsp_sync_s q;
   acsp_pkg::acsp_sync_s d;

   // first stage feeds only the second; agreement of two and three filters glitches
   always_comb begin
      d    = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.out = q.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.out;

endmodule : acsp_sync

`default_nettype wire

//--- core/acsp_port.sv
// serial configuration port of the converter: three-pin slave with staged registers
// assumes sclk from the host, chip_select_n meeting setup/hold to sclk, and that
// the host does not write while a transfer commit is crossing to clk
//
// Behaviour
// - frame starts at select low then clock rise
// - sixteen-bit instruction, then counted data bytes
// - select high: clock and data ignored
// - count 11 streams until select rises
// - select gaps at byte boundaries keep place, except when streaming
// - select rise mid-byte abandons the frame
// - select held high: pins act as straps
// - select tied low: two-wire, aligned at reset
// - instruction carries read or write flag
// - read turns data pin to output
// - msb first by default, config selects lsb
// - bits sampled on rising serial clock
// - drive after falling edge, release after rising
// - writing 01 to ff commits staged registers
// - reset loads register default values
`include "acsp_map.svh"
`default_nettype none

module acsp_port #(
   parameter logic [7:0] CHIP_ID    = 8'h5a, // arbitrary value
   parameter logic [7:0] CHIP_GRADE = 8'h40  // arbitrary value
) (
   input  wire logic         clk,                 // system clock, 100 MHz
   input  wire logic         rst_b,               // async reset, active low
   input  wire logic         sclk,                // serial clock from the host
   input  wire logic         chip_select_n,       // frame select, active low
   input  wire logic         sdio_in,             // data pin level in
   output logic              sdio_out,            // data pin level out
   output logic              sdio_oe,             // data pin driven when high
   output logic [255:0]      cfg_regs,            // committed registers, byte n at [8n+7:8n]
   output logic              test_pattern_strap,  // strap: fixed test pattern
   output logic              reduced_swing_strap  // strap: reduced output swing
);

   acsp_pkg::acsp_link_s         lq;
   acsp_pkg::acsp_link_s         ld;
   acsp_pkg::acsp_core_s         cq;
   acsp_pkg::acsp_core_s         cd;
   logic                         cs_gap_q;
   logic                         oe_fall_q;
   logic                         sdo_q;
   logic                         restart;
   logic                         lsb_first;
   logic [7:0]                   rd_byte;
   logic                         cs_s;
   logic                         sclk_s;
   logic                         sdio_s;
   logic                         xfer_s;

   // power-on contents of the register space
   function automatic logic [`ACSP_NREGS-1:0][7:0] reg_defaults();
      logic [`ACSP_NREGS-1:0][7:0] r;
      r = '0;
      r[`ACSP_ADDR_CFG]   = `ACSP_CFG_DEFAULT;
      r[`ACSP_ADDR_CLOCK] = `ACSP_CLOCK_DEFAULT;
      return r;
   endfunction : reg_defaults

   // constant image, so the reset branches load a plain constant
   localparam logic [`ACSP_NREGS-1:0][7:0] REG_DEFAULTS = reg_defaults();

   // ---------------- serial clock domain ----------------

   // set while select is high; tells the next rising edge that a gap happened
   always_ff @(posedge sclk or posedge chip_select_n or negedge rst_b) begin
      if (!rst_b || chip_select_n) begin
         cs_gap_q <= 1'b1;
      end else begin
         cs_gap_q <= 1'b0;
      end
   end

   // bit order follows the staged config so it acts within the same frame
   assign lsb_first = lq.regs[`ACSP_ADDR_CFG][`ACSP_CFG_LSB_HI]
                    | lq.regs[`ACSP_ADDR_CFG][`ACSP_CFG_LSB_LO];

   // read data for the current address; unmapped and transfer read zero
   always_comb begin
      rd_byte = 8'h00;
      if (lq.addr == `ACSP_ADDR_ID) begin
         rd_byte = CHIP_ID;
      end else if (lq.addr == `ACSP_ADDR_GRADE) begin
         rd_byte = CHIP_GRADE;
      end else if (lq.addr < 13'(`ACSP_NREGS)) begin
         rd_byte = lq.regs[lq.addr[4:0]];
      end
   end

   // instruction and data shifting, all on the rising serial edge
   always_comb begin
      logic [15:0] ins;
      logic [3:0]  cnt;
      logic [7:0]  wr;
      logic [1:0]  bc;
      ins     = 16'h0000;
      cnt     = 4'h0;
      wr      = 8'h00;
      bc      = 2'h0;
      ld      = lq;
      restart = 1'b0;
      if (!chip_select_n) begin
         // a gap mid-byte or in streaming means a fresh instruction
         restart = cs_gap_q && (lq.bit_cnt != 4'h0 || lq.stream);
         if (restart || lq.phase == acsp_pkg::ACSP_INSTR) begin
            cnt = restart ? 4'h0 : lq.bit_cnt;
            ins = restart ? 16'h0000 : lq.instr;
            ins = lsb_first ? {sdio_in, ins[15:1]} : {ins[14:0], sdio_in};
            ld.instr  = ins;
            ld.phase  = acsp_pkg::ACSP_INSTR;
            ld.stream = 1'b0;
            if (cnt == `ACSP_INSTR_LAST) begin
               bc            = ins[`ACSP_BC_HI_BIT:`ACSP_BC_LO_BIT];
               ld.phase      = acsp_pkg::ACSP_DATA;
               ld.bit_cnt    = 4'h0;
               ld.rw         = ins[`ACSP_RW_BIT];
               ld.bytes_left = bc;
               ld.stream     = (bc == `ACSP_BC_STREAM);
               ld.addr       = ins[`ACSP_ADDR_MSB:0];
            end else begin
               ld.bit_cnt = 4'(cnt + 4'h1);
            end
         end else begin
            wr = lsb_first ? {sdio_in, lq.wr_sh[7:1]} : {lq.wr_sh[6:0], sdio_in};
            ld.wr_sh = wr;
            if (lq.bit_cnt == `ACSP_BYTE_LAST) begin
               if (!lq.rw) begin
                  if (lq.addr == `ACSP_ADDR_XFER) begin
                     if (wr == `ACSP_XFER_GO) begin
                        ld.xfer_tgl = ~lq.xfer_tgl;
                     end
                  end else if (lq.addr == `ACSP_ADDR_CFG
                               && (wr[`ACSP_CFG_SRST_HI] || wr[`ACSP_CFG_SRST_LO])) begin
                     ld.regs = REG_DEFAULTS; // soft reset, bits clear themselves
                  end else if (lq.addr < 13'(`ACSP_NREGS) && lq.addr != `ACSP_ADDR_ID
                               && lq.addr != `ACSP_ADDR_GRADE) begin
                     ld.regs[lq.addr[4:0]] = wr;
                  end
               end
               ld.bit_cnt = 4'h0;
               ld.addr    = 13'(lq.addr + 13'h0001);
               if (!lq.stream && lq.bytes_left == 2'h0) begin
                  ld.phase = acsp_pkg::ACSP_INSTR; // two-wire must stay framed
               end else if (!lq.stream) begin
                  ld.bytes_left = 2'(lq.bytes_left - 2'h1);
               end
            end else begin
               ld.bit_cnt = 4'(lq.bit_cnt + 4'h1);
            end
         end
      end
   end

   // reset aligns the bit counter, which is all two-wire mode has to sync on
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         lq      <= '0;
         lq.regs <= REG_DEFAULTS;
      end else begin
         lq <= ld;
      end
   end

   // read bits change on the falling edge; select high releases the pin at once
   always_ff @(negedge sclk or negedge rst_b or posedge chip_select_n) begin
      if (!rst_b || chip_select_n) begin
         oe_fall_q <= 1'b0;
         sdo_q     <= 1'b0;
      end else begin
         oe_fall_q <= (lq.phase == acsp_pkg::ACSP_DATA) && lq.rw;
         sdo_q     <= lsb_first ? rd_byte[lq.bit_cnt[2:0]]
                                : rd_byte[3'(3'h7 - lq.bit_cnt[2:0])];
      end
   end

   // leaving the data phase on the last rising edge drops the enable right after it
   assign sdio_oe  = oe_fall_q && lq.rw && (lq.phase == acsp_pkg::ACSP_DATA);
   assign sdio_out = sdo_q;

   // ---------------- system clock domain ----------------

   acsp_sync u_sync_cs (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (chip_select_n),
      .dout  (cs_s)
   );

   acsp_sync u_sync_sclk (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (sclk),
      .dout  (sclk_s)
   );

   acsp_sync u_sync_sdio (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (sdio_in),
      .dout  (sdio_s)
   );

   acsp_sync u_sync_xfer (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (lq.xfer_tgl),
      .dout  (xfer_s)
   );

   // commit and strap capture; staged bytes are copied unheld, so the host must not write while the toggle crosses
   always_comb begin
      cd = cq;
      if (cq.rel_cnt != `ACSP_STRAP_WAIT) begin
         cd.rel_cnt = 3'(cq.rel_cnt + 3'h1);
         if (3'(cq.rel_cnt + 3'h1) == `ACSP_STRAP_WAIT) begin
            cd.strap_mode = cs_s;
         end
      end else if (!cs_s) begin
         cd.strap_mode = 1'b0; // any select low means the port is in use
      end
      cd.tp = cq.strap_mode & sclk_s;
      cd.rs = cq.strap_mode & sdio_s;
      if (xfer_s != cq.xfer_seen) begin
         cd.xfer_seen = xfer_s;
         cd.active    = lq.regs;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cq        <= '0;
         cq.active <= REG_DEFAULTS;
      end else begin
         cq <= cd;
      end
   end

   assign cfg_regs            = cq.active;
   assign test_pattern_strap  = cq.tp;
   assign reduced_swing_strap = cq.rs;

   // ---------------- checks ----------------

   a_instr_to_data: assert property (@(posedge sclk) disable iff (!rst_b)
      (!chip_select_n && !restart && lq.phase == acsp_pkg::ACSP_INSTR
       && lq.bit_cnt == 4'hf) |=> (lq.phase == acsp_pkg::ACSP_DATA && lq.bit_cnt == 4'h0))
      else $error("instruction phase did not end after sixteen bits");

   a_cs_high_hold: assert property (@(posedge sclk) disable iff (!rst_b)
      chip_select_n |=> $stable(lq))
      else $error("serial state moved while select was high");

   a_stream_stays: assert property (@(posedge sclk) disable iff (!rst_b)
      (!chip_select_n && !restart && lq.stream && lq.phase == acsp_pkg::ACSP_DATA)
      |=> (lq.phase == acsp_pkg::ACSP_DATA && lq.stream))
      else $error("streaming ended without select rising");

   a_resume_gap: assert property (@(posedge sclk) disable iff (!rst_b)
      (!chip_select_n && cs_gap_q && !lq.stream && lq.bit_cnt == 4'h0
       && lq.phase == acsp_pkg::ACSP_DATA) |=> (lq.phase == acsp_pkg::ACSP_DATA
       && lq.bit_cnt == 4'h1 && lq.addr == $past(lq.addr)))
      else $error("transfer lost its place across a byte-boundary gap");

   a_midbyte_abort: assert property (@(posedge sclk) disable iff (!rst_b)
      (!chip_select_n && restart) |=> (lq.phase == acsp_pkg::ACSP_INSTR && lq.bit_cnt == 4'h1))
      else $error("mid-byte select rise did not restart the instruction");

   a_read_drive: assert property (@(posedge sclk) disable iff (!rst_b)
      (!chip_select_n && !restart && lq.rw && lq.phase == acsp_pkg::ACSP_DATA
       && lq.bit_cnt != 4'h0) |-> sdio_oe)
      else $error("data pin not driven during readback");

   a_read_release: assert property (@(posedge sclk) disable iff (!rst_b)
      (!chip_select_n && !restart && lq.rw && lq.phase == acsp_pkg::ACSP_DATA
       && lq.bit_cnt == 4'h7 && !lq.stream && lq.bytes_left == 2'h0) |=> !sdio_oe)
      else $error("data pin not released after the last read bit");

   a_addr_step: assert property (@(posedge sclk) disable iff (!rst_b)
      (!chip_select_n && !restart && lq.phase == acsp_pkg::ACSP_DATA && lq.bit_cnt == 4'h7)
      |=> (lq.addr == 13'($past(lq.addr) + 13'h0001)))
      else $error("address did not step after a data byte");

   a_commit_copy: assert property (@(posedge clk) disable iff (!rst_b)
      (xfer_s != cq.xfer_seen) |=> (cq.active == $past(lq.regs)))
      else $error("transfer did not commit the staged registers");

   a_no_commit: assert property (@(posedge clk) disable iff (!rst_b)
      (xfer_s == cq.xfer_seen) |=> $stable(cq.active))
      else $error("committed registers changed without a transfer");

   a_strap_off: assert property (@(posedge clk) disable iff (!rst_b)
      !cq.strap_mode |=> (!test_pattern_strap && !reduced_swing_strap))
      else $error("strap output active outside strap mode");

   a_cfg_default: assert property (@(posedge clk) disable iff (!rst_b)
      (cq.rel_cnt == 3'h0) |-> (cq.active[0] == 8'h18 && cq.active[9] == 8'h01))
      else $error("registers not at defaults after reset");

endmodule : acsp_port

`default_nettype wire

//--- dv/acsp_host.sv
// host side model of the serial configuration port: clock, select and data pin
// assumes the bench resolves the data wire from both enables, with a pull-down
`default_nettype none

module acsp_host (
   output logic      sclk,          // serial clock, still outside frames
   output logic      chip_select_n, // frame select, active low
   output logic      host_d,        // host data level
   output logic      host_oe,       // host drives the data pin
   input  wire logic sdio,          // resolved data wire
   input  wire logic dev_oe         // device drives the data pin
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] dat [4]; // bytes to send, replaced by bytes seen
   logic       lsb;     // bit order in use
   int         oe_err;  // device enable wrong at a sample

   // idle: clock low and select high
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      host_d = 1'b0;
      host_oe = 1'b0;
      lsb = 1'b0;
      oe_err = 0;
   end

   // one bit: data set while the clock is low, taken just before the rise
   task automatic bitx(input logic b, input logic drv, output logic r);
      host_oe = drv;
      host_d = drv ? b : 1'b0; // released pin falls to the pull-down level
      #40;
      r = sdio;
      if (dev_oe !== !drv) oe_err++;
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
   endtask : bitx

   // n bits of v in the current order
   task automatic shift(input logic [15:0] v, input int n, input logic drv,
                        output logic [15:0] r);
      logic b;
      r = 16'h0000;
      for (int i = 0; i < n; i++) begin
         bitx(v[lsb ? i : n - 1 - i], drv, b);
         r[lsb ? i : n - 1 - i] = b;
      end
   endtask : shift

   // instruction then nb bytes; gap lifts select between bytes, keep holds it low
   task automatic frame(input logic rw, input logic [1:0] bc, input logic [12:0] a,
                        input int nb, input logic gap, input logic keep);
      logic [15:0] r;
      chip_select_n = 1'b0;
      #20;
      shift({rw, bc, a}, 16, 1'b1, r);
      for (int k = 0; k < nb; k++) begin
         if (gap && k > 0) begin
            chip_select_n = 1'b1;
            #200;
            chip_select_n = 1'b0;
            #20;
         end
         shift({8'h00, dat[k]}, 8, !rw, r);
         dat[k] = r[7:0];
      end
      host_oe = 1'b0;
      #20;
      if (!keep) chip_select_n = 1'b1;
      #100;
   endtask : frame

   // write instruction then a partial byte, select lifted mid-byte
   task automatic cut(input logic [12:0] a, input logic [3:0] v);
      logic [15:0] r;
      chip_select_n = 1'b0;
      #20;
      shift({3'b000, a}, 16, 1'b1, r);
      shift({12'h000, v}, 4, 1'b1, r);
      host_oe = 1'b0;
      #20;
      chip_select_n = 1'b1;
      #100;
   endtask : cut

endmodule : acsp_host

`default_nettype wire

//--- dv/acsp_port_tb.sv
// self-checking bench of the serial configuration port
// assumes acsp_port and acsp_host compiled before; data wire has a pull-down
`default_nettype none

module acsp_port_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic         clk;
   logic         rst_b;
   logic         sclk;
   logic         chip_select_n;
   logic         host_d;
   logic         host_oe;
   logic         sdio_out;
   logic         sdio_oe;
   logic         sdio;
   logic         tps;
   logic         rss;
   logic [255:0] cfg_regs;
   logic [15:0]  junk;
   int           failures;
   int           cmp_count;

   // wire level: device, else host, else pull-down
   assign sdio = sdio_oe ? sdio_out : (host_oe ? host_d : 1'b0);

   acsp_port #(.CHIP_ID(8'h5a), .CHIP_GRADE(8'h40)) u_dut (
      .clk(clk), .rst_b(rst_b), .sclk(sclk), .chip_select_n(chip_select_n),
      .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .cfg_regs(cfg_regs),
      .test_pattern_strap(tps), .reduced_swing_strap(rss));

   acsp_host u_host (
      .sclk(sclk), .chip_select_n(chip_select_n), .host_d(host_d),
      .host_oe(host_oe), .sdio(sdio), .dev_oe(sdio_oe));

   // system clock, 100 MHz
   always #5 clk = ~clk;

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [12:0] a, input logic [7:0] v);
      u_host.dat[0] = v;
      u_host.frame(1'b0, 2'b00, a, 1, 1'b0, 1'b0);
   endtask : wr

   task automatic rd(input logic [12:0] a, input logic [7:0] e, input string nm);
      u_host.frame(1'b1, 2'b00, a, 1, 1'b0, 1'b0);
      check(nm, u_host.dat[0], e);
   endtask : rd

   // commit staged bytes, then give the crossing time to land
   task automatic commit;
      wr(13'h00ff, 8'h01);
      repeat (20) @(negedge clk);
   endtask : commit

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   // main sequence; select stays high through reset so the straps are taken
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      failures = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      @(negedge clk) rst_b <= 1'b1;
      repeat (12) @(negedge clk);
      for (int n = 0; n < 32; n++)
         check("reset_byte", cfg_regs[8*n +: 8], n == 0 ? 8'h18 : (n == 9 ? 8'h01 : 8'h00));
      u_host.sclk = 1'b1;
      u_host.host_oe = 1'b1;
      u_host.host_d = 1'b1;
      repeat (10) @(negedge clk);
      check("strap_tp", {7'h00, tps}, 8'h01);
      check("strap_rs", {7'h00, rss}, 8'h01);
      u_host.sclk = 1'b0;
      u_host.host_oe = 1'b0;
      repeat (10) @(negedge clk);
      check("strap_low", {6'h00, tps, rss}, 8'h00);
      // clocking with select high must not start a frame
      u_host.shift(16'hffff, 16, 1'b1, junk);
      u_host.host_oe = 1'b0;
      #200;
      wr(13'h0009, 8'h5c);
      check("staged_only", cfg_regs[79:72], 8'h01);
      rd(13'h0009, 8'h5c, "read_staged");
      commit;
      check("committed", cfg_regs[79:72], 8'h5c);
      u_host.dat = '{8'h11, 8'h22, 8'h33, 8'h00};
      u_host.frame(1'b0, 2'b10, 13'h0003, 3, 1'b1, 1'b0);
      u_host.dat = '{8'h00, 8'h00, 8'h00, 8'h00};
      u_host.frame(1'b1, 2'b11, 13'h0003, 3, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++)
         check("stream_rd", u_host.dat[k], 8'(8'h11 * (k + 1)));
      u_host.cut(13'h0006, 4'hf);
      wr(13'h0007, 8'ha5);
      rd(13'h0006, 8'h00, "cut_byte");
      rd(13'h0007, 8'ha5, "after_cut");
      u_host.dat[0] = 8'h66;
      u_host.frame(1'b0, 2'b00, 13'h0008, 1, 1'b0, 1'b1);
      rd(13'h0008, 8'h66, "two_wire");
      wr(13'h0000, 8'h42);
      u_host.lsb = 1'b1;
      wr(13'h000a, 8'h3c);
      rd(13'h000a, 8'h3c, "lsb_read");
      commit;
      check("lsb_cfg", cfg_regs[7:0], 8'h42);
      check("lsb_byte", cfg_regs[87:80], 8'h3c);
      // soft reset restores staged defaults, which also returns to msb first
      wr(13'h0000, 8'h24);
      u_host.lsb = 1'b0;
      rd(13'h000a, 8'h00, "soft_reset");
      rd(13'h0001, 8'h5a, "chip_id");
      check("dev_oe", 8'(u_host.oe_err), 8'h00);
      wrap_up;
   end

   // watchdog: the sequence needs well under 100 us
   initial begin
      #500000;
      failures++;
      wrap_up;
   end

endmodule : acsp_port_tb

`default_nettype wire
